// *** hw/rpsc_regs.svh ***
// Purpose: timing and encoding constants for reset and pin state control
// Assumes: one clock (ext_ref_clock_in domain) at 250 MHz
// Notes: counts are in clock cycles
`ifndef RPSC_REGS_SVH
`define RPSC_REGS_SVH
`define RPSC_CMD_SOFT_RESET 8'h01
`define RPSC_CMD_SOFT_STBY 8'h02
`define RPSC_CMD_WAKE 8'h03
`define RPSC_FIRST_CMD_CYC 8'h64
`define RPSC_CLK_BEFORE_REL 8'h0A
`define RPSC_RESET_PULSE_CYC 8'h32
`define RPSC_SOFT_RESET_CYC 8'h10
`define RPSC_CNT_W 8
`endif

// *** hw/rpsc_pkg.sv ***
// Purpose: shared types for reset and pin state control
// Assumes: included constants header
// Notes: state codes are one-hot
`default_nettype none
package rpsc_pkg;
	typedef enum logic [3:0] {
		RPSC_ST_RESET   = 4'h1,
		RPSC_ST_DEFAULT = 4'h2,
		RPSC_ST_HSTBY   = 4'h4,
		RPSC_ST_SSTBY   = 4'h8
	} rpsc_state_type;
	typedef logic [7:0] rpsc_cmd_type;
endpackage
`default_nettype wire

// *** hw/rpsc_link_if.sv ***
// Purpose: pin-level link between sequencer device and host
// Assumes: open-drain lines resolved by the testbench from enables
// Notes: no clocking block
`timescale 1ns/1ps
`default_nettype none
interface rpsc_link_if;
	logic reset_in_n;
	logic standby_in;
	logic cmd_valid;
	logic [7:0] cmd_data;
	logic slave_address_select;
	logic external_regulator_select;
	logic slave_twowire_data_i;
	logic slave_twowire_data_o;
	logic slave_twowire_data_oe;
	logic flash_sclk_o;
	logic flash_sclk_oe;
	logic flash_serial_data_out;
	logic flash_sdo_oe;
	logic flash_cs_n_o;
	logic flash_cs_oe;
	logic flash_sdi_pullup_en;
	logic sensor_clock_out;
	logic sensor_reset_n;
	logic master_twowire_clk_oe;
	logic master_twowire_data_oe;
	logic diff_rx_enable;
	logic ready;
	modport dev (
		input  reset_in_n, standby_in, cmd_valid, cmd_data, slave_address_select,
		input  external_regulator_select, slave_twowire_data_i,
		output slave_twowire_data_o, slave_twowire_data_oe, flash_sclk_o, flash_sclk_oe,
		output flash_serial_data_out, flash_sdo_oe, flash_cs_n_o, flash_cs_oe,
		output flash_sdi_pullup_en, sensor_clock_out, sensor_reset_n,
		output master_twowire_clk_oe, master_twowire_data_oe, diff_rx_enable, ready
	);
	modport host (
		output reset_in_n, standby_in, cmd_valid, cmd_data, slave_address_select,
		output external_regulator_select, slave_twowire_data_i,
		input  slave_twowire_data_o, slave_twowire_data_oe, flash_sclk_o, flash_sclk_oe,
		input  flash_serial_data_out, flash_sdo_oe, flash_cs_n_o, flash_cs_oe,
		input  flash_sdi_pullup_en, sensor_clock_out, sensor_reset_n,
		input  master_twowire_clk_oe, master_twowire_data_oe, diff_rx_enable, ready
	);
endinterface
`default_nettype wire

// *** hw/rpsc_device.sv ***
// Purpose: device end: reset sources and per-state pin control
// Assumes: clk is the external reference clock; rst is power-on reset
// Notes: streaming and idle states are not modelled
`timescale 1ns/1ps
`default_nettype none
`include "rpsc_regs.svh"
module rpsc_device
	import rpsc_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           rst,
	rpsc_link_if.dev            link,
	input  wire logic           diff_if_select,
	output logic                soft_reset_active,
	output rpsc_pkg::rpsc_state_type state
);
	import rpsc_pkg::*;

	logic               rin_s1_q, rin_s1_d;
	logic               rin_s2_q, rin_s2_d;
	logic               sby_s1_q, sby_s1_d;
	logic               sby_s2_q, sby_s2_d;
	rpsc_state_type     st_q, st_d;
	logic [`RPSC_CNT_W-1:0] srst_cnt_q, srst_cnt_d;
	logic               srst_q, srst_d;
	logic               out_rst_n_q, out_rst_n_d;
	logic               flash_oe_q, flash_oe_d;
	logic               diff_q, diff_d;
	logic               sclk_lvl_q, sclk_lvl_d;
	logic               sdo_lvl_q, sdo_lvl_d;
	logic               cs_n_lvl_q, cs_n_lvl_d;
	logic               pullup_q, pullup_d;
	logic               sens_clk_q, sens_clk_d;
	logic               slv_dat_o_q, slv_dat_o_d;
	logic               slv_dat_oe_q, slv_dat_oe_d;
	logic               mclk_oe_q, mclk_oe_d;
	logic               mdat_oe_q, mdat_oe_d;

	// shared decodes: one place to change a command code
	function automatic logic cmd_is(input logic vld, input rpsc_cmd_type data,
			input rpsc_cmd_type code);
		return vld && (data == code);
	endfunction

	function automatic logic is_standby(input rpsc_state_type s);
		return (s == RPSC_ST_HSTBY) || (s == RPSC_ST_SSTBY);
	endfunction

	// reset input and standby are pins: two flops before use
	always_comb begin
		rin_s1_d = link.reset_in_n;
		rin_s2_d = rin_s1_q;
		sby_s1_d = link.standby_in;
		sby_s2_d = sby_s1_q;
	end

	always_comb begin
		st_d = st_q;
		srst_cnt_d = srst_cnt_q;
		srst_d = srst_q;
		if (!rin_s2_q) begin
			st_d = RPSC_ST_RESET;
			srst_d = 1'b0;
		end else begin
			case (st_q)
				RPSC_ST_RESET: begin
					st_d = RPSC_ST_DEFAULT;
				end
				RPSC_ST_DEFAULT: begin
					if (sby_s2_q)
						st_d = RPSC_ST_HSTBY;
					else if (cmd_is(link.cmd_valid, link.cmd_data, `RPSC_CMD_SOFT_STBY))
						st_d = RPSC_ST_SSTBY;
				end
				RPSC_ST_HSTBY: begin
					if (!sby_s2_q)
						st_d = RPSC_ST_DEFAULT;
				end
				RPSC_ST_SSTBY: begin
					if (sby_s2_q)
						st_d = RPSC_ST_HSTBY;
					else if (cmd_is(link.cmd_valid, link.cmd_data, `RPSC_CMD_WAKE))
						st_d = RPSC_ST_DEFAULT;
				end
				default: st_d = RPSC_ST_RESET;
			endcase
			// soft reset: internal state back to default, no pin involved
			if (srst_q) begin
				if (srst_cnt_q == `RPSC_SOFT_RESET_CYC) begin
					srst_d = 1'b0;
					srst_cnt_d = '0;
				end else begin
					srst_cnt_d = srst_cnt_q + 8'h01;
				end
				st_d = RPSC_ST_DEFAULT;
			end else if (cmd_is(link.cmd_valid, link.cmd_data, `RPSC_CMD_SOFT_RESET)) begin
				srst_d = 1'b1;
				srst_cnt_d = '0;
				st_d = RPSC_ST_DEFAULT;
			end
		end
		out_rst_n_d = is_standby(st_d);
		flash_oe_d = (st_d != RPSC_ST_RESET);
		diff_d = diff_if_select && is_standby(st_d);
	end

	// rst is the internal power-on reset, separate from the pin
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rin_s1_q <= 1'b0;
			rin_s2_q <= 1'b0;
			sby_s1_q <= 1'b0;
			sby_s2_q <= 1'b0;
			st_q <= RPSC_ST_RESET;
			srst_cnt_q <= '0;
			srst_q <= 1'b0;
			out_rst_n_q <= 1'b0;
			flash_oe_q <= 1'b0;
			diff_q <= 1'b0;
		end else begin
			rin_s1_q <= rin_s1_d;
			rin_s2_q <= rin_s2_d;
			sby_s1_q <= sby_s1_d;
			sby_s2_q <= sby_s2_d;
			st_q <= st_d;
			srst_cnt_q <= srst_cnt_d;
			srst_q <= srst_d;
			out_rst_n_q <= out_rst_n_d;
			flash_oe_q <= flash_oe_d;
			diff_q <= diff_d;
		end
	end

	// flash and sensor idle levels; the enables alone decide float
	always_comb begin
		sclk_lvl_d = 1'b0;
		sdo_lvl_d = 1'b0;
		cs_n_lvl_d = 1'b1;
		pullup_d = 1'b1;
		sens_clk_d = 1'b0;
		slv_dat_o_d = 1'b0;
		slv_dat_oe_d = 1'b0;
		mclk_oe_d = 1'b0;
		mdat_oe_d = 1'b0;
	end

	// reset values match the driven levels, so rst falling moves no pin
	// pull-up has no off state, not even under rst
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_lvl_q <= 1'b0;
			sdo_lvl_q <= 1'b0;
			cs_n_lvl_q <= 1'b1;
			pullup_q <= 1'b1;
			sens_clk_q <= 1'b0;
			slv_dat_o_q <= 1'b0;
			slv_dat_oe_q <= 1'b0;
			mclk_oe_q <= 1'b0;
			mdat_oe_q <= 1'b0;
		end else begin
			sclk_lvl_q <= sclk_lvl_d;
			sdo_lvl_q <= sdo_lvl_d;
			cs_n_lvl_q <= cs_n_lvl_d;
			pullup_q <= pullup_d;
			sens_clk_q <= sens_clk_d;
			slv_dat_o_q <= slv_dat_o_d;
			slv_dat_oe_q <= slv_dat_oe_d;
			mclk_oe_q <= mclk_oe_d;
			mdat_oe_q <= mdat_oe_d;
		end
	end

	// every pin leaves a flop; idle levels kept even while floated
	assign link.slave_twowire_data_o = slv_dat_o_q;
	assign link.slave_twowire_data_oe = slv_dat_oe_q;
	assign link.flash_sclk_o = sclk_lvl_q;
	assign link.flash_sclk_oe = flash_oe_q;
	assign link.flash_serial_data_out = sdo_lvl_q;
	assign link.flash_sdo_oe = flash_oe_q;
	assign link.flash_cs_n_o = cs_n_lvl_q;
	assign link.flash_cs_oe = flash_oe_q;
	assign link.flash_sdi_pullup_en = pullup_q;
	assign link.sensor_clock_out = sens_clk_q;
	assign link.sensor_reset_n = out_rst_n_q;
	assign link.master_twowire_clk_oe = mclk_oe_q;
	assign link.master_twowire_data_oe = mdat_oe_q;
	assign link.diff_rx_enable = diff_q;
	assign link.ready = flash_oe_q;
	assign soft_reset_active = srst_q;
	assign state = st_q;
endmodule // rpsc_device
`default_nettype wire

// *** hw/rpsc_host.sv ***
// Purpose: host end: drives reset, standby and commands
// Assumes: same clk as device
// Notes: command spacing obeys first-command wait
`timescale 1ns/1ps
`default_nettype none
`include "rpsc_regs.svh"
module rpsc_host
	import rpsc_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           rst,
	rpsc_link_if.host           link,
	input  wire logic           req_hard_reset,
	input  wire logic           req_standby,
	input  wire logic           req_cmd,
	input  wire rpsc_pkg::rpsc_cmd_type req_cmd_data,
	output logic                cmd_allowed
);
	import rpsc_pkg::*;

	logic [`RPSC_CNT_W-1:0] cnt_q, cnt_d;
	logic               rn_q, rn_d;
	logic               sby_q, sby_d;
	logic               ok_q, ok_d;
	logic               cv_q, cv_d;
	rpsc_cmd_type       cd_q, cd_d;

	always_comb begin
		cnt_d = cnt_q;
		rn_d = rn_q;
		ok_d = ok_q;
		sby_d = req_standby;
		cv_d = 1'b0;
		cd_d = cd_q;
		if (req_hard_reset && rn_q) begin
			rn_d = 1'b0;
			cnt_d = '0;
			ok_d = 1'b0;
		end else if (!rn_q) begin
			// clock keeps running through the low pulse
			if (cnt_q == `RPSC_RESET_PULSE_CYC) begin
				rn_d = 1'b1;
				cnt_d = '0;
			end else begin
				cnt_d = cnt_q + 8'h01;
			end
		end else if (!ok_q) begin
			if (cnt_q == `RPSC_FIRST_CMD_CYC)
				ok_d = 1'b1;
			else
				cnt_d = cnt_q + 8'h01;
		end else if (req_cmd) begin
			cv_d = 1'b1;
			cd_d = req_cmd_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			rn_q <= 1'b0;
			sby_q <= 1'b0;
			ok_q <= 1'b0;
			cv_q <= 1'b0;
			cd_q <= 8'h00;
		end else begin
			cnt_q <= cnt_d;
			rn_q <= rn_d;
			sby_q <= sby_d;
			ok_q <= ok_d;
			cv_q <= cv_d;
			cd_q <= cd_d;
		end
	end

	// all inputs held at defined levels, never floating
	assign link.reset_in_n = rn_q;
	assign link.standby_in = sby_q;
	assign link.cmd_valid = cv_q;
	assign link.cmd_data = cd_q;
	assign link.slave_address_select = 1'b0;
	assign link.external_regulator_select = 1'b0;
	assign link.slave_twowire_data_i = 1'b1;
	assign cmd_allowed = ok_q;
endmodule // rpsc_host
`default_nettype wire

// *** verif/rpsc_link_monitor.sv ***
// Purpose: pin rules on the link between device and host
// Assumes: one clock; rst is power-on reset
// Notes: state is inferred from the pins
`timescale 1ns/1ps
`default_nettype none
module rpsc_link_monitor (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       reset_in_n,
	input wire logic       standby_in,
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_data,
	input wire logic       slave_twowire_data_oe,
	input wire logic       flash_sclk_o,
	input wire logic       flash_sclk_oe,
	input wire logic       flash_serial_data_out,
	input wire logic       flash_sdo_oe,
	input wire logic       flash_cs_n_o,
	input wire logic       flash_cs_oe,
	input wire logic       flash_sdi_pullup_en,
	input wire logic       sensor_clock_out,
	input wire logic       sensor_reset_n,
	input wire logic       master_twowire_clk_oe,
	input wire logic       master_twowire_data_oe,
	input wire logic       diff_rx_enable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	slave_data_hiz_a: assert property (!slave_twowire_data_oe)
		else $error("slave data pin driven");
	master_pins_hiz_a: assert property (!master_twowire_clk_oe && !master_twowire_data_oe)
		else $error("master two-wire pin driven");
	sdi_pullup_on_a: assert property (flash_sdi_pullup_en)
		else $error("flash data-in pull-up off");
	sensor_clk_low_a: assert property (!sensor_clock_out)
		else $error("sensor clock not low");
	flash_idle_levels_a: assert property (flash_sclk_oe |-> !flash_sclk_o && !flash_serial_data_out
		&& flash_cs_n_o && flash_sdo_oe && flash_cs_oe)
		else $error("flash idle levels wrong");
	hard_reset_float_a: assert property (!reset_in_n [*4] |-> !flash_cs_oe && !sensor_reset_n)
		else $error("reset pin did not float flash pins");
	release_synced_a: assert property ($rose(reset_in_n) |-> !flash_cs_oe [*2] ##[1:6] flash_cs_oe)
		else $error("reset release timing wrong");
	diff_off_a: assert property (!sensor_reset_n |-> !diff_rx_enable)
		else $error("receivers on in reset or default");
	standby_sensor_a: assert property ((standby_in && reset_in_n) [*8] |-> sensor_reset_n)
		else $error("sensor reset low in standby");
	soft_reset_a: assert property (cmd_valid && cmd_data == 8'h01 && reset_in_n && !standby_in
		&& flash_cs_oe |-> ##[1:2] !sensor_reset_n)
		else $error("soft reset not taken");
	cover property (cmd_valid && cmd_data == 8'h02);
	cover property (sensor_reset_n && standby_in);
	cover property ($rose(reset_in_n));
endmodule // rpsc_link_monitor
`default_nettype wire

// *** verif/tb_reset_and_pin_state_control.sv ***
// Purpose: random and corner command sequences through host into device
// Assumes: host drops command requests until cmd_allowed
// Notes: commands spaced past the soft reset length
`timescale 1ns/1ps
`default_nettype none
module tb_reset_and_pin_state_control;
	import rpsc_pkg::*;
	logic clk, rst, hreq, sreq, creq, dsel, ok, srst;
	rpsc_cmd_type cdat, c;
	rpsc_state_type st, ex;
	int fails, checks_done, cyc, i;
	logic [31:0] lf;
	rpsc_link_if link ();
	rpsc_device u_rpsc_device (.clk(clk), .rst(rst), .link(link), .diff_if_select(dsel),
		.soft_reset_active(srst), .state(st));
	rpsc_host u_rpsc_host (.clk(clk), .rst(rst), .link(link), .req_hard_reset(hreq),
		.req_standby(sreq), .req_cmd(creq), .req_cmd_data(cdat), .cmd_allowed(ok));
	rpsc_link_monitor u_mon (.clk(clk), .rst(rst), .reset_in_n(link.reset_in_n),
		.standby_in(link.standby_in), .cmd_valid(link.cmd_valid), .cmd_data(link.cmd_data),
		.slave_twowire_data_oe(link.slave_twowire_data_oe), .flash_sclk_o(link.flash_sclk_o),
		.flash_sclk_oe(link.flash_sclk_oe), .flash_serial_data_out(link.flash_serial_data_out),
		.flash_sdo_oe(link.flash_sdo_oe), .flash_cs_n_o(link.flash_cs_n_o),
		.flash_cs_oe(link.flash_cs_oe), .flash_sdi_pullup_en(link.flash_sdi_pullup_en),
		.sensor_clock_out(link.sensor_clock_out), .sensor_reset_n(link.sensor_reset_n),
		.master_twowire_clk_oe(link.master_twowire_clk_oe),
		.master_twowire_data_oe(link.master_twowire_data_oe),
		.diff_rx_enable(link.diff_rx_enable));
	function logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// expected state after a command; unknown codes leave it alone
	function rpsc_state_type nxt(input rpsc_state_type s, input rpsc_cmd_type k);
		if (k == 8'h01) return RPSC_ST_DEFAULT;
		if (k == 8'h02 && s == RPSC_ST_DEFAULT) return RPSC_ST_SSTBY;
		if (k == 8'h03 && s == RPSC_ST_SSTBY) return RPSC_ST_DEFAULT;
		return s;
	endfunction
	function logic [9:0] pins(input rpsc_state_type s);
		logic r, b;
		r = (s == RPSC_ST_RESET);
		b = s[2] | s[3];
		return {s, !r, !r, !r, b, b & dsel, 1'b1};
	endfunction
	task chk(input string n, input logic [9:0] s, input logic [9:0] e);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask
	task chk_st(input string n);
		chk(n, {st, link.flash_sclk_oe, link.flash_sdo_oe,
			link.flash_cs_oe, link.sensor_reset_n, link.diff_rx_enable,
			link.flash_sdi_pullup_en}, pins(ex));
		chk({n, "_lvl"}, {1'b0, link.flash_sclk_o,
			link.flash_serial_data_out, link.flash_cs_n_o, link.sensor_clock_out,
			link.slave_twowire_data_oe, link.slave_twowire_data_o,
			link.master_twowire_clk_oe, link.master_twowire_data_oe, link.ready},
			{4'h1, 5'h00, ex != RPSC_ST_RESET});
		chk({n, "_host"}, {7'h00, link.slave_address_select,
			link.external_regulator_select, link.slave_twowire_data_i}, 10'h001);
	endtask
	task cmd(input rpsc_cmd_type k);
		creq = 1'b1;
		cdat = k;
		@(negedge clk);
		creq = 1'b0;
		repeat (4) @(negedge clk);
		if (k == 8'h01) chk("soft_active", {9'h000, srst}, 10'h001);
		repeat (20) @(negedge clk);
		ex = nxt(ex, k);
	endtask
	task wait_ok;
		for (i = 0; i < 400 && ok !== 1'b1; i++) @(negedge clk);
		chk("allowed", {9'h000, ok}, 10'h001);
		ex = RPSC_ST_DEFAULT;
		chk_st("default");
	endtask
	task summarize;
		$display("checks_done %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			fails++;
			summarize;
		end
	end
	initial begin
		{hreq, sreq, creq, dsel, fails, checks_done} = '0;
		cdat = 8'h00;
		lf = 32'hC2BFE983;
		rst = 1'b1;
		ex = RPSC_ST_RESET;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		chk_st("por");
		wait_ok;
		cmd(8'h02);
		chk_st("soft_stby");
		cmd(8'h01);
		chk_st("soft_reset");
		cmd(8'h02);
		dsel = 1'b1;
		sreq = 1'b1;
		repeat (10) @(negedge clk);
		ex = RPSC_ST_HSTBY;
		cmd(8'h02);
		chk_st("hard_stby");
		sreq = 1'b0;
		repeat (10) @(negedge clk);
		ex = RPSC_ST_DEFAULT;
		chk_st("stby_exit");
		for (int j = 0; j < 30; j++) begin
			lf = nx(lf);
			dsel = lf[8];
			c = lf[2] ? lf[7:0] : {6'h00, lf[1:0]};
			cmd(c);
			chk_st("random");
		end
		hreq = 1'b1;
		@(negedge clk);
		hreq = 1'b0;
		repeat (20) @(negedge clk);
		ex = RPSC_ST_RESET;
		chk_st("hard_reset");
		wait_ok;
		sreq = 1'b1;
		repeat (10) @(negedge clk);
		ex = RPSC_ST_HSTBY;
		chk_st("pin_stby");
		summarize;
	end
endmodule // tb_reset_and_pin_state_control
`default_nettype wire
